// file: hdl/blx_pkg.sv
// Constants for the byte logic and bit operation execute stage.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
package blx_pkg;
    // Data and address widths
    localparam int DW = 8;
    localparam int FAW = 5;
    localparam int FDEPTH = 32;
    localparam int BAW = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_WREG = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_FILE = 8'h80;
    localparam int FILE_SEL_BIT = 7;

    // Instruction word fields
    localparam int OPC_LSB = 0;
    localparam int FA_LSB = 3;
    localparam int BIT_LSB = 8;
    localparam int DST_BIT = 11;
    localparam int LIT_LSB = 16;

    // Status word fields
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_SKIP = 3;

    // Reset values
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [2:0] FLAG_RST = 3'h0;

    typedef enum logic [2:0] {
        OP_ADD_ACC_FILE = 3'b000,
        OP_AND_ACC_FILE = 3'b001,
        OP_AND_LIT_ACC  = 3'b010,
        OP_BIT_CLR_FILE = 3'b011,
        OP_BIT_SET_REG  = 3'b100,
        OP_TEST_SKIP_Z  = 3'b101,
        OP_NOP_A        = 3'b110,
        OP_NOP_B        = 3'b111
    } blx_op_t;

    typedef enum logic [0:0] {
        S_IDLE  = 1'b0,
        S_FETCH = 1'b1
    } blx_state_t;
endpackage

// file: hdl/blx_mem_if.sv
// Port bundle between the execute stage and its file register store.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface blx_mem_if;
    logic       we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [4:0] raddr;
    logic [7:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface
`default_nettype wire

// file: hdl/blx_file_mem.sv
// File register store: 32 bytes, one write port, registered read.
// Assumes the caller holds the read address one cycle ahead of use.
`timescale 1ns/1ns
`default_nettype none
module blx_file_mem
(
    input  wire logic clk_i,
    blx_mem_if.mem    port
);
    import blx_pkg::*;

    logic [DW-1:0] mem_q [FDEPTH];
    logic [DW-1:0] rdata_q;

    // Write port and registered read port
    always_ff @(posedge clk_i)
    begin
        if (port.we)
        begin
            mem_q[port.waddr] <= port.wdata;
        end
        rdata_q <= mem_q[port.raddr];
    end

    assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// file: hdl/blx_exec.sv
// Execute stage for six byte and bit instructions, Wishbone slave.
// Assumes a classic single-cycle Wishbone master on clk_i.
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module blx_exec
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [blx_pkg::BAW-1:0] wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o
);
    import blx_pkg::*;

    blx_mem_if mif ();

    blx_file_mem blx_file_mem_i (
        .clk_i (clk_i),
        .port  (mif.mem)
    );

    blx_state_t    state_q;
    logic [31:0]   instr_q;
    logic          discard_q;
    logic [DW-1:0] w_q;
    logic          c_q;
    logic          dc_q;
    logic          z_q;
    logic          skip_q;
    logic          ack_q;
    logic [31:0]   dat_q;

    // Bus request decode
    wire req      = wb_cyc_i & wb_stb_i & ~ack_q & (state_q == S_IDLE);
    wire in_file  = wb_adr_i[FILE_SEL_BIT];
    wire hit_ins  = (wb_adr_i == OFS_INSTR);
    wire hit_w    = (wb_adr_i == OFS_WREG);
    wire hit_st   = (wb_adr_i == OFS_STAT);
    wire issue    = req & wb_we_i & hit_ins & wb_sel_i[0];
    wire file_rd  = req & ~wb_we_i & in_file;
    wire file_wr  = req & wb_we_i & in_file & wb_sel_i[0];
    wire to_fetch = issue | file_rd;

    // Instruction field decode
    wire [2:0]     op_raw = instr_q[OPC_LSB +: 3];
    blx_op_t       opc;
    assign opc = blx_op_t'(op_raw);
    wire [FAW-1:0] fa     = instr_q[FA_LSB +: FAW];
    wire [2:0]     bsel   = instr_q[BIT_LSB +: 3];
    wire           dst    = instr_q[DST_BIT];
    wire [DW-1:0]  lit    = instr_q[LIT_LSB +: DW];
    wire [DW-1:0]  fval   = mif.rdata;
    wire [DW-1:0]  bmask  = 8'h01 << bsel;
    wire           exec   = (state_q == S_FETCH) & instr_q[31] & ~discard_q;

    wire [DW:0]    sum9   = {1'b0, w_q} + {1'b0, fval};
    wire [4:0]     nib5   = {1'b0, w_q[3:0]} + {1'b0, fval[3:0]};
    wire [DW-1:0]  andf   = w_q & fval;
    wire [DW-1:0]  andl   = w_q & lit;
    wire [DW-1:0]  bclr   = fval & ~bmask;
    wire [DW-1:0]  bset   = fval | bmask;
    wire           bzero  = (fval & bmask) == 8'h00;

    // Result selection per opcode
    wire is_add  = exec & (opc == OP_ADD_ACC_FILE);
    wire is_andf = exec & (opc == OP_AND_ACC_FILE);
    wire is_andl = exec & (opc == OP_AND_LIT_ACC);
    wire is_bclr = exec & (opc == OP_BIT_CLR_FILE);
    wire is_bset = exec & (opc == OP_BIT_SET_REG);
    wire is_test = exec & (opc == OP_TEST_SKIP_Z);
    wire two_op  = is_add | is_andf;
    wire [DW-1:0] res = is_add  ? sum9[DW-1:0] :
                        is_andf ? andf :
                        is_andl ? andl :
                        is_bclr ? bclr : bset;
    wire wr_w    = (two_op & ~dst) | is_andl;
    wire wr_f    = (two_op & dst) | is_bclr | is_bset;
    wire res_z   = (res == 8'h00);

    // Memory port steering; W never lives here
    // W kept apart from file space
    assign mif.we    = file_wr | wr_f;
    assign mif.waddr = file_wr ? wb_adr_i[6:2] : fa;
    assign mif.wdata = file_wr ? wb_dat_i[7:0] : res;
    assign mif.raddr = issue ? wb_dat_i[FA_LSB +: FAW] : wb_adr_i[6:2];

    // Sequencer: idle accepts, fetch executes or returns file data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q   <= S_IDLE;
            instr_q   <= 32'h0000_0000;
            discard_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    if (to_fetch)
                    begin
                        state_q <= S_FETCH;
                    end
                    if (issue)
                    begin
                        discard_q <= skip_q;
                        instr_q   <= {1'b1, wb_dat_i[30:0]};
                    end
                    else if (file_rd)
                    begin
                        // Only the marker drops; the issued word stays
                        instr_q[31] <= 1'b0;
                    end
                end
                S_FETCH:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Working register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            w_q <= WREG_RST;
        end
        else if (wr_w)
        begin
            w_q <= res;
        end
        else if (req & wb_we_i & hit_w & wb_sel_i[0])
        begin
            w_q <= wb_dat_i[7:0];
        end
    end

    // Flags and skip state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {z_q, dc_q, c_q} <= FLAG_RST;
            skip_q           <= 1'b0;
        end
        else
        begin
            if (req & wb_we_i & hit_st & wb_sel_i[0])
            begin
                c_q  <= wb_dat_i[ST_C];
                dc_q <= wb_dat_i[ST_DC];
                z_q  <= wb_dat_i[ST_Z];
            end
            if (is_add)
            begin
                c_q  <= sum9[DW];
                dc_q <= nib5[4];
                z_q  <= res_z;
            end
            if (is_andf | is_andl)
            begin
                z_q <= res_z;
            end
            // skip consumed by the next slot
            if ((state_q == S_FETCH) & discard_q)
            begin
                skip_q <= 1'b0;
            end
            if (is_test)
            begin
                skip_q <= bzero;
            end
        end
    end

    // Read data mux for the plain registers
    wire [31:0] stat_word = {28'h0000000, skip_q, z_q, dc_q, c_q};
    wire [31:0] reg_rd = hit_ins ? instr_q & 32'h7FFF_FFFF :
                         hit_w   ? {24'h000000, w_q} :
                         hit_st  ? stat_word : 32'h0000_0000;

    // Acknowledge and read data, all registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= (req & ~to_fetch) | (state_q == S_FETCH);
            if (req & ~to_fetch)
            begin
                dat_q <= wb_we_i ? 32'h0000_0000 : reg_rd;
            end
            else if (state_q == S_FETCH)
            begin
                dat_q <= instr_q[31] ? 32'h0000_0000 : {24'h000000, fval};
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule
`default_nettype wire

// file: tb/blx_exec_checker.sv
// Port checker for the execute stage Wishbone slave.
// Bound to blx_exec; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module blx_exec_checker
(
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [blx_pkg::BAW-1:0] wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o
);
    import blx_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request and two-edge answer class
    wire req_w = wb_cyc_i && wb_stb_i;
    wire rd_w = wb_ack_o && !wb_we_i;
    wire slow_w = wb_we_i ? (wb_adr_i == OFS_INSTR) : wb_adr_i[7];
    sequence s_fast; ##1 wb_ack_o; endsequence
    sequence s_slow; ##1 !wb_ack_o ##1 wb_ack_o; endsequence
    chk_fast_answer: assert property ($rose(req_w) && !slow_w |-> s_fast)
        else $error("fast access answer late");
    chk_slow_answer: assert property ($rose(req_w) && slow_w |-> s_slow)
        else $error("slow access answer wrong");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> req_w && $past(req_w))
        else $error("ack without request");
    chk_write_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 0)
        else $error("write returned data");
    chk_wreg_width: assert property (
        rd_w && wb_adr_i == OFS_WREG |-> wb_dat_o[31:8] == 0)
        else $error("working value wider than a byte");
    chk_stat_width: assert property (
        rd_w && wb_adr_i == OFS_STAT |-> wb_dat_o[31:4] == 0)
        else $error("status upper bits set");
    chk_data_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved without ack");
endmodule
bind blx_exec blx_exec_checker blx_exec_checker_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// file: tb/blx_exec_tb_top.sv
// Self-checking bench for the execute stage over Wishbone.
// Assumes ack after one or two edges, released a cycle later.
`timescale 1ns/1ns
`default_nettype none
module blx_exec_tb_top;
    import blx_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    wire  [31:0] dat_o;
    wire         ack_o;
    int          bad_count = 0;
    int          cmp_count = 0;
    blx_exec blx_exec_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o));
    // Free-running clock
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        while (n < 20 && ack_o !== 1'b1)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20)
        begin
            bad_count++;
            print_verdict();
        end
        else
        begin
            rdat = dat_o;
            cyc <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        cmp_count++;
        if (rdat !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rdat, e);
        end
    endtask
    task automatic ex(input logic [2:0] o, input logic [4:0] f,
                      input logic [2:0] b, input logic d,
                      input logic [7:0] k);
        xfer(1'b1, OFS_INSTR, {8'h00, k, 4'h0, d, b, f, o});
    endtask
    function automatic logic [7:0] fa(input logic [4:0] i);
        return {1'b1, i, 2'b00};
    endfunction
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_WREG, 32'h0);
        rd(OFS_STAT, 32'h0);
        xfer(1'b1, OFS_WREG, 32'h0F);
        xfer(1'b1, fa(5'h01), 32'hF1);
        ex(3'h0, 5'h01, 3'h0, 1'b1, 8'h00);
        rd(fa(5'h01), 32'h00);
        rd(OFS_STAT, 32'h07);
        rd(OFS_WREG, 32'h0F);
        xfer(1'b1, OFS_WREG, 32'h28);
        xfer(1'b1, fa(5'h1F), 32'h18);
        ex(3'h0, 5'h1F, 3'h0, 1'b0, 8'h00);
        rd(OFS_WREG, 32'h40);
        rd(OFS_STAT, 32'h02);
        rd(fa(5'h1F), 32'h18);
        xfer(1'b1, OFS_STAT, 32'h03);
        xfer(1'b1, fa(5'h02), 32'hC0);
        ex(3'h1, 5'h02, 3'h0, 1'b1, 8'h00);
        rd(fa(5'h02), 32'h40);
        rd(OFS_STAT, 32'h03);
        ex(3'h2, 5'h02, 3'h0, 1'b1, 8'h0F);
        rd(OFS_WREG, 32'h00);
        rd(fa(5'h02), 32'h40);
        rd(OFS_STAT, 32'h07);
        xfer(1'b1, fa(5'h03), 32'hFF);
        ex(3'h3, 5'h03, 3'h7, 1'b0, 8'h00);
        ex(3'h4, 5'h02, 3'h0, 1'b0, 8'h00);
        rd(fa(5'h03), 32'h7F);
        rd(fa(5'h02), 32'h41);
        rd(OFS_STAT, 32'h07);
        ex(3'h5, 5'h02, 3'h0, 1'b0, 8'h00);
        rd(OFS_STAT, 32'h07);
        ex(3'h5, 5'h02, 3'h1, 1'b0, 8'h00);
        rd(OFS_STAT, 32'h0F);
        ex(3'h4, 5'h02, 3'h1, 1'b0, 8'h00);
        rd(fa(5'h02), 32'h41);
        rd(OFS_STAT, 32'h07);
        ex(3'h4, 5'h02, 3'h1, 1'b0, 8'h00);
        rd(fa(5'h02), 32'h43);
        // Instruction readback survives the file read above
        rd(OFS_INSTR, 32'h0000_0114);
        // Spare opcode changes nothing
        ex(3'h6, 5'h02, 3'h0, 1'b1, 8'hFF);
        rd(fa(5'h02), 32'h43);
        rd(OFS_WREG, 32'h00);
        rd(OFS_STAT, 32'h07);
        // AND with file into the working register
        xfer(1'b1, OFS_WREG, 32'hF3);
        ex(3'h1, 5'h02, 3'h0, 1'b0, 8'h00);
        rd(OFS_WREG, 32'h43);
        rd(fa(5'h02), 32'h43);
        rd(OFS_STAT, 32'h03);
        // Pending skip survives file accesses, then eats one issue
        ex(3'h5, 5'h02, 3'h2, 1'b0, 8'h00);
        rd(fa(5'h02), 32'h43);
        rd(OFS_STAT, 32'h0B);
        ex(3'h4, 5'h02, 3'h7, 1'b0, 8'h00);
        rd(fa(5'h02), 32'h43);
        rd(OFS_STAT, 32'h03);
        // Carry out of bit seven without digit carry
        xfer(1'b1, OFS_WREG, 32'h80);
        xfer(1'b1, fa(5'h04), 32'h80);
        ex(3'h0, 5'h04, 3'h0, 1'b1, 8'h00);
        rd(fa(5'h04), 32'h00);
        rd(OFS_STAT, 32'h05);
        rd(OFS_WREG, 32'h80);
        // Reset in mid-run, held for three edges
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_WREG, 32'h0);
        rd(OFS_STAT, 32'h0);
        // Unmapped address ignores writes and reads zero
        xfer(1'b1, 8'h0C, 32'hFF);
        rd(8'h0C, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
